//--- rtl/diag_chop_regs.sv
// AXI4-Lite register bank for diagnostic levels, delayed modulator clock and chop rates
`timescale 1ns/1ps

// Behaviour
// - Receive register resets zero; bits 5,4,1,0 enable diagnostic on lanes 3..0.
// - Selector 000 off, 011 positive full, 100 negative full, 101 zero.
// - Bits [2:0] serve first group, bits [6:4] second group; both reset zero.
// - Each lane gets the level of its group from the mode select register.
// - Delay register resets 0x02; [3:2] picks none, lanes 0-1, 2-3, all.
// - Chop register resets 0x0A; [3:2] and [1:0] pick divide 8 or 32.
module diag_chop_regs
    import diag_chop_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output lane_ctl_t lane_ctl,
    output logic [1:0] first_group_chop_rate,
    output logic [1:0] second_group_chop_rate
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [31:0] waddr;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        reg_file_t regs;
        lane_ctl_t lane_ctl;
        logic [1:0] first_chop;
        logic [1:0] second_chop;
    } state_t;

    localparam state_t STATE_RESET = '{
        awready: 1'b0,
        wready: 1'b0,
        aw_held: 1'b0,
        w_held: 1'b0,
        waddr: 32'h0000_0000,
        wdata: 8'h00,
        wlane0: 1'b0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b0,
        rvalid: 1'b0,
        rdata: 32'h0000_0000,
        rresp: RESP_OKAY,
        regs: '{
            channel_mode_select: RST_CHANNEL_MODE_SELECT,
            diag_receive_select: RST_DIAG_RECEIVE_SELECT,
            diag_voltage_select: RST_DIAG_VOLTAGE_SELECT,
            modulator_clock_delay_ctl: RST_MODULATOR_CLOCK_DELAY_CTL,
            chop_rate_ctl: RST_CHOP_RATE_CTL
        },
        lane_ctl: '0,
        first_chop: RST_CHOP_RATE_CTL[FIRST_GROUP_CHOP_LSB +: 2],
        second_chop: RST_CHOP_RATE_CTL[SECOND_GROUP_CHOP_LSB +: 2]
    };

    state_t state_reg;
    state_t state_next;
    lane_ctl_t lane_ctl_comb;

    // Word address to register index; upper bits must be zero to hit
    function automatic logic addr_hit(
        input logic [31:0] addr,
        input logic [7:0] idx
    );
        addr_hit = (addr[31:10] == 22'h00_0000) && (addr[9:2] == idx);
    endfunction

    function automatic logic addr_mapped(input logic [31:0] addr);
        addr_mapped = addr_hit(addr, IDX_CHANNEL_MODE_SELECT) ||
            addr_hit(addr, IDX_DIAG_RECEIVE_SELECT) ||
            addr_hit(addr, IDX_DIAG_VOLTAGE_SELECT) ||
            addr_hit(addr, IDX_MODULATOR_CLOCK_DELAY_CTL) ||
            addr_hit(addr, IDX_CHOP_RATE_CTL);
    endfunction

    function automatic logic [7:0] read_reg(
        input reg_file_t r,
        input logic [31:0] addr
    );
        logic [7:0] v;
        v = 8'h00;
        if (addr_hit(addr, IDX_CHANNEL_MODE_SELECT)) begin
            v = r.channel_mode_select;
        end
        if (addr_hit(addr, IDX_DIAG_RECEIVE_SELECT)) begin
            v = r.diag_receive_select;
        end
        if (addr_hit(addr, IDX_DIAG_VOLTAGE_SELECT)) begin
            v = r.diag_voltage_select;
        end
        if (addr_hit(addr, IDX_MODULATOR_CLOCK_DELAY_CTL)) begin
            v = r.modulator_clock_delay_ctl;
        end
        if (addr_hit(addr, IDX_CHOP_RATE_CTL)) begin
            v = r.chop_rate_ctl;
        end
        read_reg = v;
    endfunction

    diag_lane_router u_router (
        .regs(state_reg.regs),
        .lane_ctl(lane_ctl_comb)
    );

    always_comb begin
        state_next = state_reg;

        // Write address and data are taken independently
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_held = 1'b1;
            state_next.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_held = 1'b1;
            state_next.wdata = s_axi_wdata[7:0];
            state_next.wlane0 = s_axi_wstrb[0];
        end

        // Both halves present: commit and respond
        if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            // Unmapped or out-of-range address: error response, bank untouched
            state_next.bresp = addr_mapped(state_reg.waddr) ? RESP_OKAY : RESP_SLVERR;
            if (state_reg.wlane0) begin
                if (addr_hit(state_reg.waddr, IDX_CHANNEL_MODE_SELECT)) begin
                    state_next.regs.channel_mode_select =
                        state_reg.wdata & MASK_CHANNEL_MODE_SELECT;
                end
                if (addr_hit(state_reg.waddr, IDX_DIAG_RECEIVE_SELECT)) begin
                    state_next.regs.diag_receive_select =
                        state_reg.wdata & MASK_DIAG_RECEIVE_SELECT;
                end
                if (addr_hit(state_reg.waddr, IDX_DIAG_VOLTAGE_SELECT)) begin
                    state_next.regs.diag_voltage_select =
                        state_reg.wdata & MASK_DIAG_VOLTAGE_SELECT;
                end
                if (addr_hit(state_reg.waddr, IDX_MODULATOR_CLOCK_DELAY_CTL)) begin
                    state_next.regs.modulator_clock_delay_ctl =
                        state_reg.wdata & MASK_MODULATOR_CLOCK_DELAY_CTL;
                end
                if (addr_hit(state_reg.waddr, IDX_CHOP_RATE_CTL)) begin
                    state_next.regs.chop_rate_ctl =
                        state_reg.wdata & MASK_CHOP_RATE_CTL;
                end
            end
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Read: one outstanding, answered the cycle after the address is taken
        if (s_axi_arvalid && state_reg.arready) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = {24'h00_0000, read_reg(state_reg.regs, s_axi_araddr)};
            state_next.rresp = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end

        state_next.awready = !state_next.aw_held && !state_next.bvalid;
        state_next.wready = !state_next.w_held && !state_next.bvalid;
        state_next.arready = !state_next.rvalid;

        // Registered analog steering
        state_next.lane_ctl = lane_ctl_comb;
        state_next.first_chop =
            state_reg.regs.chop_rate_ctl[FIRST_GROUP_CHOP_LSB +: 2];
        state_next.second_chop =
            state_reg.regs.chop_rate_ctl[SECOND_GROUP_CHOP_LSB +: 2];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign lane_ctl = state_reg.lane_ctl;
    assign first_group_chop_rate = state_reg.first_chop;
    assign second_group_chop_rate = state_reg.second_chop;
endmodule // diag_chop_regs

//--- rtl/diag_chop_pkg.sv
// Register map, field layout, reset values and carrier types of the diagnostic and chop bank
package diag_chop_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CHANNEL_MODE_SELECT = 8'h03;
    localparam logic [7:0] IDX_DIAG_RECEIVE_SELECT = 8'h56;
    localparam logic [7:0] IDX_DIAG_VOLTAGE_SELECT = 8'h57;
    localparam logic [7:0] IDX_MODULATOR_CLOCK_DELAY_CTL = 8'h58;
    localparam logic [7:0] IDX_CHOP_RATE_CTL = 8'h59;

    // Reset values
    localparam logic [7:0] RST_CHANNEL_MODE_SELECT = 8'h00;
    localparam logic [7:0] RST_DIAG_RECEIVE_SELECT = 8'h00;
    localparam logic [7:0] RST_DIAG_VOLTAGE_SELECT = 8'h00;
    localparam logic [7:0] RST_MODULATOR_CLOCK_DELAY_CTL = 8'h02;
    localparam logic [7:0] RST_CHOP_RATE_CTL = 8'h0a;

    // Implemented bits per register
    localparam logic [7:0] MASK_CHANNEL_MODE_SELECT = 8'h33;
    localparam logic [7:0] MASK_DIAG_RECEIVE_SELECT = 8'h33;
    localparam logic [7:0] MASK_DIAG_VOLTAGE_SELECT = 8'h77;
    localparam logic [7:0] MASK_MODULATOR_CLOCK_DELAY_CTL = 8'h0f;
    localparam logic [7:0] MASK_CHOP_RATE_CTL = 8'h0f;

    // Field positions
    localparam int NUM_LANES = 4;
    localparam int LANE_BIT [NUM_LANES] = '{0, 1, 4, 5};
    localparam int FIRST_GROUP_DIAG_LSB = 0;
    localparam int SECOND_GROUP_DIAG_LSB = 4;
    localparam int DELAYED_CLK_SEL_LSB = 2;
    localparam int FIRST_GROUP_CHOP_LSB = 2;
    localparam int SECOND_GROUP_CHOP_LSB = 0;

    // Diagnostic selector codes
    localparam logic [2:0] DIAG_CODE_OFF = 3'h0;
    localparam logic [2:0] DIAG_CODE_POS_FULL = 3'h3;
    localparam logic [2:0] DIAG_CODE_NEG_FULL = 3'h4;
    localparam logic [2:0] DIAG_CODE_ZERO = 3'h5;

    // Delayed modulator clock codes
    localparam logic [1:0] DELAY_NONE = 2'h0;
    localparam logic [1:0] DELAY_LANES_01 = 2'h1;
    localparam logic [1:0] DELAY_LANES_23 = 2'h2;
    localparam logic [1:0] DELAY_ALL = 2'h3;

    // Chop rate codes
    localparam logic [1:0] CHOP_DIV_8 = 2'h1;
    localparam logic [1:0] CHOP_DIV_32 = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        LEVEL_OFF = 2'b00,
        LEVEL_POS_FULL = 2'b01,
        LEVEL_NEG_FULL = 2'b11,
        LEVEL_ZERO = 2'b10
    } diag_level_t;

    // Per-lane analog steering
    typedef struct packed {
        diag_level_t [NUM_LANES-1:0] level;
        logic [NUM_LANES-1:0] delayed_clk;
    } lane_ctl_t;

    typedef struct packed {
        logic [7:0] channel_mode_select;
        logic [7:0] diag_receive_select;
        logic [7:0] diag_voltage_select;
        logic [7:0] modulator_clock_delay_ctl;
        logic [7:0] chop_rate_ctl;
    } reg_file_t;
endpackage

//--- rtl/diag_lane_router.sv
// Per-lane decode of diagnostic level and delayed modulator clock
`timescale 1ns/1ps
module diag_lane_router
    import diag_chop_pkg::*;
(
    input wire reg_file_t regs,
    output lane_ctl_t lane_ctl
);
    function automatic diag_level_t decode_level(input logic [2:0] code);
        unique case (code)
            DIAG_CODE_POS_FULL: decode_level = LEVEL_POS_FULL;
            DIAG_CODE_NEG_FULL: decode_level = LEVEL_NEG_FULL;
            DIAG_CODE_ZERO: decode_level = LEVEL_ZERO;
            default: decode_level = LEVEL_OFF;
        endcase
    endfunction

    logic [1:0] delay_sel;
    assign delay_sel = regs.modulator_clock_delay_ctl[DELAYED_CLK_SEL_LSB +: 2];

    genvar lane;
    generate
        for (lane = 0; lane < NUM_LANES; lane++) begin : g_lane
            logic receive;
            logic second_group;
            logic [2:0] code;
            assign receive = regs.diag_receive_select[LANE_BIT[lane]];
            assign second_group = regs.channel_mode_select[LANE_BIT[lane]];
            assign code = second_group ?
                regs.diag_voltage_select[SECOND_GROUP_DIAG_LSB +: 3] :
                regs.diag_voltage_select[FIRST_GROUP_DIAG_LSB +: 3];
            assign lane_ctl.level[lane] = receive ? decode_level(code) : LEVEL_OFF;
            assign lane_ctl.delayed_clk[lane] = (delay_sel == DELAY_ALL) ||
                ((delay_sel == DELAY_LANES_01) && (lane < 2)) ||
                ((delay_sel == DELAY_LANES_23) && (lane >= 2));
        end
    endgenerate
endmodule // diag_lane_router

//--- verification/diag_chop_regs_props.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
module diag_chop_regs_props
    import diag_chop_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire lane_ctl_t lane_ctl,
    input wire logic [1:0] first_group_chop_rate,
    input wire logic [1:0] second_group_chop_rate
);
    logic [31:0] aw_q;
    logic [7:0] w_q;
    logic st_q;
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
        if (s_axi_wvalid && s_axi_wready) st_q <= s_axi_wstrb[0];
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Write answered, register just updated
    sequence wr_done(a);
        $rose(s_axi_bvalid) && aw_q == a && st_q;
    endsequence
    a_reset_outputs: assert property ($rose(aresetn) |->
        lane_ctl == '0 && first_group_chop_rate == 2'h2 &&
        second_group_chop_rate == 2'h2) else $error("reset out");
    a_chop_write: assert property (wr_done(32'h0000_0164) |=>
        {first_group_chop_rate, second_group_chop_rate} == w_q[3:0]) else $error("chop rate");
    a_delay_write: assert property (wr_done(32'h0000_0160) |=>
        lane_ctl.delayed_clk == {{2{w_q[3]}}, {2{w_q[2]}}}) else $error("delayed clock");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
        else $error("write answer late");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule // diag_chop_regs_props
bind diag_chop_regs diag_chop_regs_props i_diag_chop_regs_props (.*);

//--- verification/axi_host_model.sv
// Host software model driving the register bank over AXI4-Lite
`timescale 1ns/1ps
module axi_host_model (
    input wire logic aclk,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    output logic [31:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    logic slow = 1'b0;
    // Receiving lanes rely on input buffers enabled elsewhere
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic s,
        output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= {3'h0, s};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule // axi_host_model

//--- verification/adc_diag_chop_config_regs_test.sv
// Self-checking bench for the diagnostic and chop register bank
`timescale 1ns/1ps
module adc_diag_chop_config_regs_test
    import diag_chop_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, first_group_chop_rate, second_group_chop_rate, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    lane_ctl_t lane_ctl;
    int n_mismatch = 0;
    int checks = 0;
    logic [7:0] regs [5];
    localparam logic [7:0] IDX [5] = '{8'h03, 8'h56, 8'h57, 8'h58, 8'h59};
    localparam logic [7:0] MSK [5] = '{8'h33, 8'h33, 8'h77, 8'h0f, 8'h0f};
    localparam logic [7:0] RST [5] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h0a};
    localparam logic [2:0] CODE [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h1, 3'h7};
    diag_chop_regs i_diag_chop_regs (.*);
    axi_host_model i_axi_host_model (.*);
    always #5 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
        chk(n, {30'h0, e}, {30'h0, g});
    endtask
    task automatic put(input int k, input logic [31:0] v, input logic s);
        i_axi_host_model.wr({22'h0, IDX[k], 2'h0}, v, s, r);
        chk_resp("bresp", RESP_OKAY, r);
        if (s) regs[k] = v[7:0] & MSK[k];
    endtask
    task automatic get(input int k);
        i_axi_host_model.rd({22'h0, IDX[k], 2'h0}, d, r);
        chk_resp("rresp", RESP_OKAY, r);
        chk("register", {24'h0, regs[k]}, d);
    endtask
    function automatic lane_ctl_t lanes_exp();
        lane_ctl_t e;
        logic [2:0] c;
        for (int l = 0; l < 4; l++) begin
            c = regs[0][LANE_BIT[l]] ? regs[2][6:4] : regs[2][2:0];
            e.level[l] = c == 3'h3 ? LEVEL_POS_FULL : c == 3'h4 ? LEVEL_NEG_FULL :
                c == 3'h5 ? LEVEL_ZERO : LEVEL_OFF;
            if (!regs[1][LANE_BIT[l]]) e.level[l] = LEVEL_OFF;
        end
        e.delayed_clk = {{2{regs[3][3]}}, {2{regs[3][2]}}};
        return e;
    endfunction
    task automatic chk_steer();
        chk("lanes", 32'(lanes_exp()), 32'(lane_ctl));
        chk("chop", {28'h0, regs[4][3:0]},
            {28'h0, first_group_chop_rate, second_group_chop_rate});
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #100_000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h0f5b));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 5; k++) begin
            regs[k] = RST[k];
            get(k);
        end
        chk_steer();
        i_axi_host_model.wr(32'h0000_0168, 32'h0000_00ff, 1'b1, r);
        chk_resp("unmapped bresp", RESP_SLVERR, r);
        i_axi_host_model.rd(32'h0000_0168, d, r);
        chk_resp("unmapped rresp", RESP_SLVERR, r);
        chk("unmapped rdata", 32'h0000_0000, d);
        i_axi_host_model.wr(32'h0000_0558, 32'h0000_00ff, 1'b1, r);
        chk_resp("aliased bresp", RESP_SLVERR, r);
        for (int k = 0; k < 5; k++) get(k);
        for (int i = 0; i < 40; i++) begin
            i_axi_host_model.slow = i[0];
            put(0, $urandom, 1'b1);
            put(1, $urandom, 1'b1);
            put(2, {25'($urandom), CODE[$urandom % 6], 1'($urandom), CODE[$urandom % 6]}, 1'b1);
            put(3, {28'($urandom), i[1:0], 2'h2}, 1'b1);
            put(4, {28'($urandom), i[3:0]}, 1'b1);
            put(i % 5, $urandom, 1'b0);
            chk_steer();
            for (int k = 0; k < 5; k++) get(k);
        end
        // Mid-run reset returns every register and steering output to reset
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 5; k++) begin
            regs[k] = RST[k];
            get(k);
        end
        chk_steer();
        finish_test();
    end
endmodule // adc_diag_chop_config_regs_test
